//--- hw/oaf_operand_decoder.sv
// Operand addressing and greater-than flags with an APB register file
`timescale 1ns/100ps
`default_nettype none
module oaf_operand_decoder (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire oaf_pkg::oaf_addr_t paddr,
  input  wire oaf_pkg::oaf_bus_t  pwdata,
  output oaf_pkg::oaf_bus_t       prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    logical_greater_flag,
  output logic                    arithmetic_greater_flag,
  output logic                    done
);
  import oaf_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  oaf_op_e    op_reg;
  logic       exec_reg;
  logic       done_reg;
  oaf_word_t  instr_reg;
  oaf_word_t  ext0_reg;
  oaf_word_t  ext1_reg;
  oaf_word_t  wp_reg;
  oaf_word_t  src_rv_reg;
  oaf_word_t  dst_rv_reg;
  oaf_word_t  sa_reg;
  oaf_word_t  da_reg;
  oaf_word_t  pc_reg;
  oaf_word_t  bit_base_reg;
  oaf_word_t  sel_wr_reg;
  oaf_word_t  status_reg;
  oaf_word_t  src_ea_reg;
  oaf_word_t  dst_ea_reg;
  oaf_word_t  src_new_reg;
  oaf_word_t  dst_new_reg;
  oaf_word_t  pc_next_reg;
  oaf_word_t  bit_addr_reg;
  oaf_word_t  imm_reg;
  oaf_word_t  wb_reg;
  logic [3:0] upd_reg;
  oaf_bus_t   prdata_reg;
  logic       pready_reg;
  logic       pslverr_reg;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic [1:0] src_mode;
  logic [1:0] dst_mode;
  logic [3:0] src_rnum;
  logic [3:0] dst_rnum;
  logic       dual_fmt;
  logic       byte_op;
  logic       both_sym;
  oaf_word_t  dst_base;
  oaf_word_t  pc_target;
  oaf_word_t  bit_addr_sum;
  logic [7:0] disp;

  assign src_mode = instr_reg[SRC_MODE_HI -: 2];
  assign dst_mode = instr_reg[DST_MODE_HI -: 2];
  assign src_rnum = instr_reg[S_HI -: 4];
  assign dst_rnum = instr_reg[D_HI -: 4];
  assign disp     = instr_reg[DISP_MSB:0];
  assign dual_fmt = (op_reg == OP_DUAL) || (op_reg == OP_CMP) ||
                    (op_reg == OP_ARITH);
  // Byte indicator only means something in the two-operand format
  assign byte_op  = dual_fmt && instr_reg[B_POS];
  assign both_sym = (src_mode == MODE_IDX) && (dst_mode == MODE_IDX);
  // Second extension belongs to the destination only when both need one
  assign dst_base = both_sym ? ext1_reg : ext0_reg;
  assign pc_target = pc_reg + {{7{disp[DISP_MSB]}}, disp, 1'b0};
  // Low bit of the base word is not part of the serial base
  assign bit_addr_sum = {1'b0, bit_base_reg[WORD_MSB:1]} +
                        {{8{disp[DISP_MSB]}}, disp};

  // ----------------------------------------------------------------
  // Datapath units
  // ----------------------------------------------------------------
  oaf_ea_s   src_res;
  oaf_ea_s   dst_res;
  oaf_flag_s flag_cur;
  oaf_flag_s flag_nxt;
  oaf_word_t flag_sa;
  oaf_word_t flag_da;

  oaf_ea_unit u_src_ea (
    .mode    (src_mode),
    .rnum    (src_rnum),
    .wp      (wp_reg),
    .rval    (src_rv_reg),
    .base    (ext0_reg),
    .byte_op (byte_op),
    .res     (src_res)
  );

  oaf_ea_unit u_dst_ea (
    .mode    (dst_mode),
    .rnum    (dst_rnum),
    .wp      (wp_reg),
    .rval    (dst_rv_reg),
    .base    (dst_base),
    .byte_op (byte_op),
    .res     (dst_res)
  );

  // Compare immediate: register plays source, immediate plays dest
  assign flag_sa  = (op_reg == OP_CMP_IMM) ? src_rv_reg : sa_reg;
  assign flag_da  = (op_reg == OP_CMP_IMM) ? ext0_reg : da_reg;
  assign flag_cur = '{lgt: status_reg[LGT_BIT], agt: status_reg[AGT_BIT]};

  oaf_flag_unit u_flags (
    .op      (op_reg),
    .sa      (flag_sa),
    .da      (flag_da),
    .sel_wr  (sel_wr_reg),
    .byte_op (byte_op),
    .cur     (flag_cur),
    .nxt     (flag_nxt)
  );

  // ----------------------------------------------------------------
  // APB slave: one wait-free access cycle, reply built in setup
  // ----------------------------------------------------------------
  logic      setup;
  logic      wr_en;
  logic      hit;
  oaf_word_t rd_word;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;

  always_comb begin
    hit     = 1'b1;
    rd_word = WORD_ZERO;
    if (paddr == A_CTRL) rd_word = 16'(op_reg);
    else if (paddr == A_INSTR) rd_word = instr_reg;
    else if (paddr == A_EXT0) rd_word = ext0_reg;
    else if (paddr == A_EXT1) rd_word = ext1_reg;
    else if (paddr == A_WP) rd_word = wp_reg;
    else if (paddr == A_SRC_RV) rd_word = src_rv_reg;
    else if (paddr == A_DST_RV) rd_word = dst_rv_reg;
    else if (paddr == A_SA) rd_word = sa_reg;
    else if (paddr == A_DA) rd_word = da_reg;
    else if (paddr == A_PC) rd_word = pc_reg;
    else if (paddr == A_BIT_BASE) rd_word = bit_base_reg;
    else if (paddr == A_SEL_WR) rd_word = sel_wr_reg;
    else if (paddr == A_STATUS) rd_word = status_reg;
    else if (paddr == A_SRC_EA) rd_word = src_ea_reg;
    else if (paddr == A_DST_EA) rd_word = dst_ea_reg;
    else if (paddr == A_SRC_NEW) rd_word = src_new_reg;
    else if (paddr == A_DST_NEW) rd_word = dst_new_reg;
    else if (paddr == A_PC_NEXT) rd_word = pc_next_reg;
    else if (paddr == A_BIT_ADDR) rd_word = bit_addr_reg;
    else if (paddr == A_IMM) rd_word = imm_reg;
    else if (paddr == A_WB) rd_word = wb_reg;
    else if (paddr == A_UPD) rd_word = 16'(upd_reg);
    else hit = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !hit;
      if (setup) begin
        prdata_reg <= BW'(rd_word);
      end
    end
  end

  // ----------------------------------------------------------------
  // Software-written inputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      op_reg     <= OP_NONE;
      exec_reg   <= 1'b0;
      instr_reg  <= '0;
      ext0_reg   <= '0;
      ext1_reg   <= '0;
      wp_reg     <= '0;
      src_rv_reg <= '0;
      dst_rv_reg <= '0;
      sa_reg     <= '0;
      da_reg     <= '0;
      pc_reg     <= '0;
      bit_base_reg <= '0;
      sel_wr_reg <= '0;
    end else begin
      // A control write launches one evaluation cycle
      exec_reg <= wr_en && (paddr == A_CTRL);
      if (wr_en) begin
        if (paddr == A_CTRL) op_reg <= oaf_op_e'(pwdata[OP_W-1:0]);
        else if (paddr == A_INSTR) instr_reg <= pwdata[DW-1:0];
        else if (paddr == A_EXT0) ext0_reg <= pwdata[DW-1:0];
        else if (paddr == A_EXT1) ext1_reg <= pwdata[DW-1:0];
        else if (paddr == A_WP) wp_reg <= pwdata[DW-1:0];
        else if (paddr == A_SRC_RV) src_rv_reg <= pwdata[DW-1:0];
        else if (paddr == A_DST_RV) dst_rv_reg <= pwdata[DW-1:0];
        else if (paddr == A_SA) sa_reg <= pwdata[DW-1:0];
        else if (paddr == A_DA) da_reg <= pwdata[DW-1:0];
        else if (paddr == A_PC) pc_reg <= pwdata[DW-1:0];
        else if (paddr == A_BIT_BASE) bit_base_reg <= pwdata[DW-1:0];
        else if (paddr == A_SEL_WR) sel_wr_reg <= pwdata[DW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Evaluation results
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_reg    <= 1'b0;
      src_ea_reg  <= '0;
      dst_ea_reg  <= '0;
      src_new_reg <= '0;
      dst_new_reg <= '0;
      pc_next_reg <= '0;
      bit_addr_reg <= '0;
      imm_reg     <= '0;
      wb_reg      <= '0;
      upd_reg     <= '0;
    end else begin
      done_reg <= exec_reg;
      if (exec_reg) begin
        src_ea_reg  <= src_res.ea;
        dst_ea_reg  <= dst_res.ea;
        src_new_reg <= src_res.new_reg;
        dst_new_reg <= dst_res.new_reg;
        upd_reg     <= {dst_res.is_reg, src_res.is_reg,
                        dst_res.upd, src_res.upd};
        pc_next_reg <= (op_reg == OP_JUMP) ? pc_target : pc_reg;
        bit_addr_reg <= bit_addr_sum;
        imm_reg     <= ext0_reg;
        // Byte store into a register must not touch its right byte
        wb_reg <= (byte_op && dst_mode == MODE_REG) ?
                  ((da_reg & BYTE_MASK) | (dst_rv_reg & ~BYTE_MASK)) :
                  da_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_reg <= STATUS_RESET;
    end else if (exec_reg) begin
      // Hardware update outranks a software write in the same cycle
      status_reg[LGT_BIT] <= flag_nxt.lgt;
      status_reg[AGT_BIT] <= flag_nxt.agt;
    end else if (wr_en && paddr == A_STATUS) begin
      status_reg <= pwdata[DW-1:0];
    end
  end

  assign prdata                  = prdata_reg;
  assign pready                  = pready_reg;
  assign pslverr                 = pslverr_reg;
  assign done                    = done_reg;
  assign logical_greater_flag    = status_reg[LGT_BIT];
  assign arithmetic_greater_flag = status_reg[AGT_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking main_clk @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_reg_direct_ea: assert property (
    exec_reg && src_mode == MODE_REG |=>
      src_ea_reg == $past(wp_reg + 16'({src_rnum, 1'b0})) && upd_reg[2])
    else $error("register operand address wrong");

  a_indirect_ea: assert property (
    exec_reg && src_mode == MODE_IND |=> src_ea_reg ==
      $past(byte_op ? src_rv_reg : (src_rv_reg & WORD_LSB_MASK)))
    else $error("indirect address wrong");

  a_autoinc_step: assert property (
    exec_reg && src_mode == MODE_AUTO |=> upd_reg[0] && src_new_reg ==
      $past(src_rv_reg + (byte_op ? INC_BYTE : INC_WORD)))
    else $error("auto increment step wrong");

  a_autoinc_addr: assert property (
    exec_reg && dst_mode == MODE_AUTO && !byte_op |=>
      dst_ea_reg == $past(dst_rv_reg & WORD_LSB_MASK))
    else $error("address not taken before increment");

  a_symbolic_ea: assert property (
    exec_reg && src_mode == MODE_IDX && src_rnum == RNUM_ZERO |=>
      src_ea_reg == $past(byte_op ? ext0_reg : (ext0_reg & WORD_LSB_MASK)))
    else $error("symbolic address wrong");

  a_indexed_ea: assert property (
    exec_reg && src_mode == MODE_IDX && src_rnum != RNUM_ZERO |=>
      src_ea_reg == $past(byte_op ? (ext0_reg + src_rv_reg) :
                          ((ext0_reg + src_rv_reg) & WORD_LSB_MASK)))
    else $error("indexed address wrong");

  a_ext_order: assert property (
    exec_reg && both_sym && dst_rnum == RNUM_ZERO |=> dst_ea_reg ==
      $past(byte_op ? ext1_reg : (ext1_reg & WORD_LSB_MASK)))
    else $error("destination did not use second extension");

  a_imm_value: assert property (
    exec_reg |=> imm_reg == $past(ext0_reg))
    else $error("immediate operand wrong");

  a_jump_target: assert property (
    exec_reg && op_reg == OP_JUMP |=> pc_next_reg ==
      $past(pc_reg + (16'($signed(disp)) << 1)))
    else $error("jump target wrong");

  a_bit_addr: assert property (
    exec_reg |=> bit_addr_reg ==
      $past((bit_base_reg >> 1) + 16'($signed(disp))))
    else $error("serial bit address wrong");

  a_byte_keep: assert property (
    exec_reg && byte_op && dst_mode == MODE_REG |=>
      (wb_reg & ~BYTE_MASK) == $past(dst_rv_reg & ~BYTE_MASK))
    else $error("register right byte disturbed");

  a_cmp_flags: assert property (
    exec_reg && op_reg == OP_CMP && !byte_op |=>
      logical_greater_flag == $past(sa_reg > da_reg) &&
      arithmetic_greater_flag == $past($signed(sa_reg) > $signed(da_reg)))
    else $error("compare flags wrong");

  a_arith_agt: assert property (
    exec_reg && op_reg == OP_ARITH && !byte_op |=>
      arithmetic_greater_flag == $past($signed(da_reg) > 0))
    else $error("result flag wrong");

  a_restore_flags: assert property (
    exec_reg && (op_reg == OP_RETURN || op_reg == OP_LOAD_STATUS) |=>
      logical_greater_flag == $past(sel_wr_reg[LGT_BIT]) &&
      arithmetic_greater_flag == $past(sel_wr_reg[AGT_BIT]))
    else $error("restored flags wrong");

  a_reset_flags: assert property (
    exec_reg && op_reg == OP_RESET |=>
      !logical_greater_flag && !arithmetic_greater_flag)
    else $error("reset did not clear flags");

  a_hold_flags: assert property (
    exec_reg && (op_reg == OP_EXEC_IND || op_reg == OP_JUMP) |=>
      $stable(status_reg))
    else $error("flags changed by non-affecting op");
endmodule
`default_nettype wire

//--- include/oaf_pkg.sv
// Shared constants, types and register map of the operand decoder
package oaf_pkg;
  // ----------------------------------------------------------------
  // Widths and types
  // ----------------------------------------------------------------
  localparam int DW       = 16;
  localparam int BW       = 32;
  localparam int AW       = 8;
  localparam int OP_W     = 4;
  localparam int WORD_MSB = DW - 1;

  typedef logic [DW-1:0] oaf_word_t;
  typedef logic [BW-1:0] oaf_bus_t;
  typedef logic [AW-1:0] oaf_addr_t;

  typedef enum logic [OP_W-1:0] {
    OP_NONE, OP_DUAL, OP_CMP, OP_CMP_IMM, OP_ARITH, OP_ABS_SERIAL,
    OP_RETURN, OP_LOAD_STATUS, OP_JUMP, OP_SERIAL_BIT, OP_IMM,
    OP_EXEC_IND, OP_RESET
  } oaf_op_e;

  typedef struct packed {
    oaf_word_t ea;
    oaf_word_t new_reg;
    logic      upd;
    logic      is_reg;
  } oaf_ea_s;

  typedef struct packed {
    logic lgt;
    logic agt;
  } oaf_flag_s;

  // ----------------------------------------------------------------
  // Instruction fields and mode codes
  // ----------------------------------------------------------------
  localparam int B_POS    = 12;
  localparam int DST_MODE_HI = 11;
  localparam int D_HI     = 9;
  localparam int SRC_MODE_HI = 5;
  localparam int S_HI     = 3;
  localparam int DISP_MSB = 7;
  localparam int LGT_BIT  = 15;
  localparam int AGT_BIT  = 14;

  localparam logic [1:0] MODE_REG  = 2'h0;
  localparam logic [1:0] MODE_IND  = 2'h1;
  localparam logic [1:0] MODE_IDX  = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;
  localparam logic [3:0] RNUM_ZERO = 4'h0;

  localparam oaf_word_t INC_BYTE      = 16'h0001;
  localparam oaf_word_t INC_WORD      = 16'h0002;
  localparam oaf_word_t WORD_LSB_MASK = 16'hFFFE;
  localparam oaf_word_t BYTE_MASK     = 16'hFF00;
  localparam oaf_word_t STATUS_RESET  = 16'h0000;
  localparam oaf_word_t WORD_ZERO     = 16'h0000;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam oaf_addr_t A_CTRL    = 8'h00;
  localparam oaf_addr_t A_INSTR   = 8'h04;
  localparam oaf_addr_t A_EXT0    = 8'h08;
  localparam oaf_addr_t A_EXT1    = 8'h0C;
  localparam oaf_addr_t A_WP      = 8'h10;
  localparam oaf_addr_t A_SRC_RV  = 8'h14;
  localparam oaf_addr_t A_DST_RV  = 8'h18;
  localparam oaf_addr_t A_SA      = 8'h1C;
  localparam oaf_addr_t A_DA      = 8'h20;
  localparam oaf_addr_t A_PC      = 8'h24;
  localparam oaf_addr_t A_BIT_BASE = 8'h28;
  localparam oaf_addr_t A_SEL_WR  = 8'h2C;
  localparam oaf_addr_t A_STATUS  = 8'h30;
  localparam oaf_addr_t A_SRC_EA  = 8'h34;
  localparam oaf_addr_t A_DST_EA  = 8'h38;
  localparam oaf_addr_t A_SRC_NEW = 8'h3C;
  localparam oaf_addr_t A_DST_NEW = 8'h40;
  localparam oaf_addr_t A_PC_NEXT = 8'h44;
  localparam oaf_addr_t A_BIT_ADDR = 8'h48;
  localparam oaf_addr_t A_IMM     = 8'h4C;
  localparam oaf_addr_t A_WB      = 8'h50;
  localparam oaf_addr_t A_UPD     = 8'h54;
endpackage

//--- hw/oaf_ea_unit.sv
// Effective address former for one operand
`timescale 1ns/100ps
`default_nettype none
module oaf_ea_unit (
  input  wire logic              [1:0] mode,
  input  wire logic              [3:0] rnum,
  input  wire oaf_pkg::oaf_word_t      wp,
  input  wire oaf_pkg::oaf_word_t      rval,
  input  wire oaf_pkg::oaf_word_t      base,
  input  wire logic                    byte_op,
  output oaf_pkg::oaf_ea_s             res
);
  import oaf_pkg::*;

  always_comb begin
    res         = '0;
    res.new_reg = rval;
    case (mode)
      MODE_REG: begin
        // Register operand lives at its workspace slot
        res.ea     = wp + 16'({rnum, 1'b0});
        res.is_reg = 1'b1;
      end
      MODE_IND: begin
        res.ea = rval;
      end
      MODE_AUTO: begin
        // Address taken before the pointer moves
        res.ea      = rval;
        res.new_reg = rval + (byte_op ? INC_BYTE : INC_WORD);
        res.upd     = 1'b1;
      end
      default: begin
        if (rnum == RNUM_ZERO) begin
          res.ea = base;
        end else begin
          res.ea = base + rval;
        end
      end
    endcase
    if (!byte_op) begin
      res.ea = res.ea & WORD_LSB_MASK;
    end
  end
endmodule
`default_nettype wire

//--- hw/oaf_flag_unit.sv
// Next value of the two greater-than status flags
`timescale 1ns/100ps
`default_nettype none
module oaf_flag_unit (
  input  wire oaf_pkg::oaf_op_e   op,
  input  wire oaf_pkg::oaf_word_t sa,
  input  wire oaf_pkg::oaf_word_t da,
  input  wire oaf_pkg::oaf_word_t sel_wr,
  input  wire logic               byte_op,
  input  wire oaf_pkg::oaf_flag_s cur,
  output oaf_pkg::oaf_flag_s      nxt
);
  import oaf_pkg::*;

  oaf_word_t s;
  oaf_word_t d;
  oaf_word_t diff;

  always_comb begin
    // Byte operands sit in the left byte, so bit 15 stays the sign
    s    = byte_op ? (sa & BYTE_MASK) : sa;
    d    = byte_op ? (da & BYTE_MASK) : da;
    diff = d - s;
    nxt  = cur;
    case (op)
      OP_CMP, OP_CMP_IMM: begin
        nxt.lgt = (s[WORD_MSB] & ~d[WORD_MSB]) |
                  ((s[WORD_MSB] == d[WORD_MSB]) & diff[WORD_MSB]);
        nxt.agt = (~s[WORD_MSB] & d[WORD_MSB]) |
                  ((s[WORD_MSB] == d[WORD_MSB]) & diff[WORD_MSB]);
      end
      OP_ARITH: begin
        nxt.lgt = (d != WORD_ZERO);
        nxt.agt = (d != WORD_ZERO) & ~d[WORD_MSB];
      end
      OP_ABS_SERIAL: begin
        nxt.lgt = (s != WORD_ZERO);
        nxt.agt = (s != WORD_ZERO) & ~s[WORD_MSB];
      end
      OP_RETURN, OP_LOAD_STATUS: begin
        nxt.lgt = sel_wr[LGT_BIT];
        nxt.agt = sel_wr[AGT_BIT];
      end
      OP_RESET: begin
        nxt = '0;
      end
      default: begin
        nxt = cur;
      end
    endcase
  end
endmodule
`default_nettype wire

//--- bench/oaf_apb_master.sv
// APB master standing in for the processor side of the decoder
`timescale 1ns/100ps
`default_nettype none
module oaf_apb_master (
  input  wire logic              clock,
  input  wire logic              pready,
  input  wire oaf_pkg::oaf_bus_t prdata,
  input  wire logic              pslverr,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output oaf_pkg::oaf_addr_t     paddr,
  output oaf_pkg::oaf_bus_t      pwdata
);
  import oaf_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // ----------------------------------------------------------------
  // One transfer
  // ----------------------------------------------------------------
  // Request held until pready; no wait length assumed, bounded loop
  task automatic xfer(input logic w, input oaf_addr_t a, input oaf_word_t d,
                      output oaf_bus_t r, output logic e, output logic to);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    to = 1'b1;
    r = 32'h00000000;
    e = 1'b0;
    while (to && n < 16) begin
      @(posedge clock);
      n++;
      if (pready === 1'b1) begin
        r = prdata;
        e = pslverr;
        to = 1'b0;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- bench/oaf_operand_decoder_bench.sv
// Self-checking bench of the operand decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
      n_fail++; \
      $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end \
  end
module oaf_operand_decoder_bench;
  import oaf_pkg::*;
  logic      clock = 1'b0;
  logic      rst_n = 1'b0;
  logic      psel, penable, pwrite, pready, pslverr, lgt, agt, done;
  oaf_addr_t paddr;
  oaf_bus_t  pwdata, prdata;
  int        n_fail = 0;
  int        n_checks = 0;
  always #10 clock = ~clock;
  oaf_operand_decoder oaf_operand_decoder_inst (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .logical_greater_flag(lgt),
    .arithmetic_greater_flag(agt), .done(done));
  oaf_apb_master oaf_apb_master_inst (
    .clock(clock), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input oaf_addr_t a, input oaf_word_t d,
                     output oaf_bus_t r, output logic e);
    logic t;
    oaf_apb_master_inst.xfer(w, a, d, r, e, t);
    if (t) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic wr(input oaf_addr_t a, input oaf_word_t d);
    oaf_bus_t r;
    logic e;
    bus(1'b1, a, d, r, e);
  endtask
  task automatic chk(input oaf_addr_t a, input oaf_word_t ex);
    oaf_bus_t r;
    logic e;
    bus(1'b0, a, 16'h0000, r, e);
    `CHK($sformatf("reg %h", a), {16'h0000, ex}, r)
  endtask
  // Results land two edges after the start; done waited for, bounded
  task automatic run(input oaf_op_e op);
    int n;
    wr(A_CTRL, {12'h000, op});
    n = 0;
    while (done !== 1'b1 && n < 16) begin
      @(posedge clock);
      n++;
    end
    `CHK("done", 1'b1, done)
    if (done !== 1'b1) begin
      summarize();
    end
  endtask
  task automatic flg(input oaf_op_e op, input oaf_word_t sa, da, sel,
                     input logic el, ea);
    wr(A_SA, sa);
    wr(A_DA, da);
    wr(A_SEL_WR, sel);
    run(op);
    `CHK("lgt", el, lgt)
    `CHK("agt", ea, agt)
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    oaf_bus_t r;
    logic     e;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    chk(A_STATUS, 16'h0000);
    wr(A_WP, 16'h0100);
    wr(A_DST_RV, 16'h2001);
    wr(A_INSTR, 16'h0C83);
    run(OP_DUAL);
    chk(A_SRC_EA, 16'h0106);
    chk(A_DST_EA, 16'h2000);
    chk(A_DST_NEW, 16'h2003);
    wr(A_INSTR, 16'h1C83);
    run(OP_DUAL);
    chk(A_DST_EA, 16'h2001);
    chk(A_DST_NEW, 16'h2002);
    wr(A_EXT0, 16'h4444);
    wr(A_DST_RV, 16'h3000);
    wr(A_INSTR, 16'h0460);
    run(OP_DUAL);
    chk(A_SRC_EA, 16'h4444);
    chk(A_DST_EA, 16'h3000);
    wr(A_SRC_RV, 16'h0010);
    wr(A_EXT1, 16'h5556);
    wr(A_INSTR, 16'h0821);
    run(OP_DUAL);
    chk(A_SRC_EA, 16'h4454);
    chk(A_DST_EA, 16'h5556);
    wr(A_INSTR, 16'h0012);
    run(OP_DUAL);
    chk(A_SRC_EA, 16'h0010);
    wr(A_DA, 16'hAB00);
    wr(A_DST_RV, 16'h1234);
    wr(A_INSTR, 16'h1040);
    run(OP_DUAL);
    chk(A_WB, 16'hAB34);
    wr(A_PC, 16'h1000);
    wr(A_INSTR, 16'h00FE);
    run(OP_JUMP);
    chk(A_PC_NEXT, 16'h0FFC);
    wr(A_INSTR, 16'h007F);
    run(OP_JUMP);
    chk(A_PC_NEXT, 16'h10FE);
    wr(A_BIT_BASE, 16'h0040);
    wr(A_INSTR, 16'h00FF);
    run(OP_SERIAL_BIT);
    chk(A_BIT_ADDR, 16'h001F);
    wr(A_EXT0, 16'hBEEF);
    run(OP_IMM);
    chk(A_IMM, 16'hBEEF);
    wr(A_INSTR, 16'h0000);
    flg(OP_CMP, 16'h0001, 16'h8000, 16'h0000, 1'b0, 1'b1);
    flg(OP_CMP, 16'h8000, 16'h0001, 16'h0000, 1'b1, 1'b0);
    flg(OP_EXEC_IND, 16'h0000, 16'h0000, 16'hC000, 1'b1, 1'b0);
    flg(OP_ARITH, 16'h0000, 16'h0005, 16'h0000, 1'b1, 1'b1);
    flg(OP_ARITH, 16'h0000, 16'h8000, 16'h0000, 1'b1, 1'b0);
    flg(OP_RETURN, 16'h0000, 16'h0000, 16'h4000, 1'b0, 1'b1);
    flg(OP_ABS_SERIAL, 16'h0005, 16'h0000, 16'h0000, 1'b1, 1'b1);
    flg(OP_LOAD_STATUS, 16'h0000, 16'h0000, 16'h8000, 1'b1, 1'b0);
    chk(A_STATUS, 16'h8000);
    flg(OP_RESET, 16'h0000, 16'h0000, 16'hC000, 1'b0, 1'b0);
    wr(A_SRC_RV, 16'h0002);
    wr(A_EXT0, 16'h0001);
    run(OP_CMP_IMM);
    `CHK("lgt", 1'b1, lgt)
    `CHK("agt", 1'b1, agt)
    wr(A_STATUS, 16'hC000);
    chk(A_STATUS, 16'hC000);
    // Reset in mid-run must clear flags that are set
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    `CHK("lgt", 1'b0, lgt)
    `CHK("agt", 1'b0, agt)
    chk(A_STATUS, 16'h0000);
    bus(1'b0, 8'hFC, 16'h0000, r, e);
    `CHK("pslverr", 1'b1, e)
    `CHK("unmapped", 32'h00000000, r)
    summarize();
  end
endmodule
`default_nettype wire
